// File: dol_pkg.sv
`default_nettype none
package dol_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [5:0] DOL_ADDR_FREQ_CFG = 6'h19;
	localparam logic [5:0] DOL_ADDR_TIMING_CFG = 6'h1a;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int DOL_GATE_BIT = 5;
	localparam int DOL_FPRE_LSB = 3;
	localparam int DOL_FPOST_BIT = 2;
	localparam int DOL_FSAT_LSB = 0;
	localparam int DOL_TKI_LSB = 6;
	localparam int DOL_TKP_LSB = 4;
	localparam int DOL_TKI_POST_BIT = 3;
	localparam int DOL_TKP_POST_BIT = 2;
	localparam int DOL_RSAT_LSB = 0;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic DOL_RST_GATE = 1'b1;
	localparam logic [1:0] DOL_RST_FPRE = 2'h2;
	localparam logic DOL_RST_FPOST = 1'b1;
	localparam logic [1:0] DOL_RST_FSAT = 2'h2;
	localparam logic [1:0] DOL_RST_TKI = 2'h1;
	localparam logic [1:0] DOL_RST_TKP = 2'h2;
	localparam logic DOL_RST_TKI_POST = 1'b1;
	localparam logic DOL_RST_TKP_POST = 1'b1;
	localparam logic [1:0] DOL_RST_RSAT = 2'h0;

	// gain in half-base units: 1 = base/2, 2 = base, 8 = 4x base
	localparam logic [3:0] DOL_GAIN_HALF = 4'h1;
	localparam logic [3:0] DOL_GAIN_BASE = 4'h2;

	// reception phase
	typedef enum logic [1:0] {
		DOL_ST_PRE = 2'b00,
		DOL_ST_SYNCED = 2'b01
	} dol_phase_t;

	// settings handed to the loop arithmetic
	typedef struct packed {
		logic frozen;
		logic [3:0] freq_gain;
		logic [1:0] freq_sat;
		logic [3:0] timing_ki;
		logic [3:0] timing_kp;
		logic [1:0] rate_sat;
	} dol_loop_ctrl_t;

endpackage : dol_pkg
`default_nettype wire

// File: dol_offset_loop_cfg.sv
`timescale 1ns/1ns
`default_nettype none
module dol_offset_loop_cfg
	import dol_pkg::*;
#(
	parameter int ADDR_W = 6
) (
	input wire logic clk, // 50 MHz digital clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic [ADDR_W-1:0] reg_addr, // register address
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data, one cycle after strobe
	input wire logic rx_start, // a new reception begins
	input wire logic sync_found, // sync word detected pulse
	input wire logic carrier_sense, // carrier sense level
	output dol_loop_ctrl_t loop_ctrl // settings for both loops
);

	// ---------------------------------------------------------------
	// parameter check
	// ---------------------------------------------------------------
	if (ADDR_W < 6) begin : g_bad_addr
		$error("ADDR_W must be at least 6");
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	logic gate_r;
	logic [1:0] fpre_r;
	logic fpost_r;
	logic [1:0] fsat_r;
	logic [1:0] tki_r;
	logic [1:0] tkp_r;
	logic tki_post_r;
	logic tkp_post_r;
	logic [1:0] rsat_r;
	logic wr_freq;
	logic wr_timing;
	logic [7:0] freq_view;
	logic [7:0] timing_view;
	logic [7:0] rdata_nxt;

	assign wr_freq = reg_wr && (reg_addr == ADDR_W'(DOL_ADDR_FREQ_CFG));
	assign wr_timing = reg_wr && (reg_addr == ADDR_W'(DOL_ADDR_TIMING_CFG));

	// frequency loop register; bits 7:6 are not stored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gate_r <= DOL_RST_GATE;
			fpre_r <= DOL_RST_FPRE;
			fpost_r <= DOL_RST_FPOST;
			fsat_r <= DOL_RST_FSAT;
		end else if (wr_freq) begin
			gate_r <= reg_wdata[DOL_GATE_BIT];
			fpre_r <= reg_wdata[DOL_FPRE_LSB +: 2];
			fpost_r <= reg_wdata[DOL_FPOST_BIT];
			fsat_r <= reg_wdata[DOL_FSAT_LSB +: 2];
		end
	end

	// timing loop register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tki_r <= DOL_RST_TKI;
			tkp_r <= DOL_RST_TKP;
			tki_post_r <= DOL_RST_TKI_POST;
			tkp_post_r <= DOL_RST_TKP_POST;
			rsat_r <= DOL_RST_RSAT;
		end else if (wr_timing) begin
			tki_r <= reg_wdata[DOL_TKI_LSB +: 2];
			tkp_r <= reg_wdata[DOL_TKP_LSB +: 2];
			tki_post_r <= reg_wdata[DOL_TKI_POST_BIT];
			tkp_post_r <= reg_wdata[DOL_TKP_POST_BIT];
			rsat_r <= reg_wdata[DOL_RSAT_LSB +: 2];
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	// reassemble register views; reserved bits read zero
	always_comb begin
		freq_view = 8'h00;
		freq_view[DOL_GATE_BIT] = gate_r;
		freq_view[DOL_FPRE_LSB +: 2] = fpre_r;
		freq_view[DOL_FPOST_BIT] = fpost_r;
		freq_view[DOL_FSAT_LSB +: 2] = fsat_r;
		timing_view = 8'h00;
		timing_view[DOL_TKI_LSB +: 2] = tki_r;
		timing_view[DOL_TKP_LSB +: 2] = tkp_r;
		timing_view[DOL_TKI_POST_BIT] = tki_post_r;
		timing_view[DOL_TKP_POST_BIT] = tkp_post_r;
		timing_view[DOL_RSAT_LSB +: 2] = rsat_r;
	end

	// select by address; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_addr == ADDR_W'(DOL_ADDR_FREQ_CFG)) begin
			rdata_nxt = freq_view;
		end else if (reg_addr == ADDR_W'(DOL_ADDR_TIMING_CFG)) begin
			rdata_nxt = timing_view;
		end
	end

	// read data held until the next read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end
	end

	// ---------------------------------------------------------------
	// reception phase and carrier gate
	// ---------------------------------------------------------------
	dol_phase_t phase_r;
	logic carrier_seen_r;
	logic synced;

	// sync switches to post gains; new reception reverts unless sync_found comes in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_r <= DOL_ST_PRE;
		end else begin
			unique case (phase_r)
				DOL_ST_PRE: begin
					if (sync_found) begin
						phase_r <= DOL_ST_SYNCED;
					end
				end
				DOL_ST_SYNCED: begin
					if (rx_start && !sync_found) begin
						phase_r <= DOL_ST_PRE;
					end
				end
				default: begin
					phase_r <= DOL_ST_PRE;
				end
			endcase
		end
	end

	// remembers carrier since reception start; a new carrier wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			carrier_seen_r <= 1'b0;
		end else if (carrier_sense) begin
			carrier_seen_r <= 1'b1;
		end else if (rx_start) begin
			carrier_seen_r <= 1'b0;
		end
	end

	// post gains take effect in the very cycle sync is flagged
	assign synced = (phase_r == DOL_ST_SYNCED) || sync_found;

	// ---------------------------------------------------------------
	// loop settings
	// ---------------------------------------------------------------
	// gain codes scaled to half-base units (code n -> (n+1)*base)
	always_comb begin
		loop_ctrl.frozen = gate_r && !carrier_seen_r && !carrier_sense;
		// widen before adding so code 3 gives 8, not a wrapped 0
		loop_ctrl.freq_gain = 4'({fpre_r, 1'b0}) + DOL_GAIN_BASE;
		if (synced && fpost_r) begin
			loop_ctrl.freq_gain = DOL_GAIN_HALF;
		end
		loop_ctrl.freq_sat = fsat_r;
		loop_ctrl.timing_ki = 4'({tki_r, 1'b0}) + DOL_GAIN_BASE;
		if (synced && tki_post_r) begin
			loop_ctrl.timing_ki = DOL_GAIN_HALF;
		end
		loop_ctrl.timing_kp = 4'({tkp_r, 1'b0}) + DOL_GAIN_BASE;
		if (synced && tkp_post_r) begin
			loop_ctrl.timing_kp = DOL_GAIN_BASE;
		end
		loop_ctrl.rate_sat = rsat_r;
	end

endmodule : dol_offset_loop_cfg
`default_nettype wire

// File: dol_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dol_chk
	import dol_pkg::*;
#(parameter int ADDR_W = 6) (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic [ADDR_W-1:0] reg_addr, // address
	input wire logic reg_wr, // write
	input wire logic reg_rd, // read
	input wire logic [7:0] reg_wdata, // write data
	input wire logic [7:0] reg_rdata, // read data
	input wire logic rx_start, // reception start
	input wire logic sync_found, // sync pulse
	input wire logic carrier_sense, // carrier
	input wire dol_loop_ctrl_t loop_ctrl // loop settings
);
	// low write bits for the saturation checks
	wire logic [1:0] wd_lo = reg_wdata[1:0];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_cs; carrier_sense |-> !loop_ctrl.frozen; endproperty
	a_cs: assert property (p_cs) else $error("frozen in carrier");
	property p_hold; !loop_ctrl.frozen && !rx_start && !reg_wr
		|=> !loop_ctrl.frozen; endproperty
	a_hold: assert property (p_hold) else $error("refrozen");
	property p_fg; loop_ctrl.freq_gain inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
	endproperty
	a_fg: assert property (p_fg) else $error("freq gain");
	property p_tg; loop_ctrl.timing_kp inside {4'h2, 4'h4, 4'h6, 4'h8}
		&& loop_ctrl.timing_ki inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
	endproperty
	a_tg: assert property (p_tg) else $error("timing gain");
	property p_sync; sync_found && !reg_wr ##1 !rx_start && !reg_wr |->
		$stable({loop_ctrl.freq_gain, loop_ctrl.timing_ki, loop_ctrl.timing_kp});
	endproperty
	a_sync: assert property (p_sync) else $error("post gain lost");
	property p_pre; rx_start && !sync_found && !reg_wr
		|=> sync_found || !loop_ctrl.freq_gain[0]; endproperty
	a_pre: assert property (p_pre) else $error("pre gain");
	property p_fsat; reg_wr && reg_addr == DOL_ADDR_FREQ_CFG
		|=> loop_ctrl.freq_sat == $past(wd_lo); endproperty
	a_fsat: assert property (p_fsat) else $error("freq sat");
	property p_rsat; reg_wr && reg_addr == DOL_ADDR_TIMING_CFG
		|=> loop_ctrl.rate_sat == $past(wd_lo); endproperty
	a_rsat: assert property (p_rsat) else $error("rate sat");
endmodule : dol_chk
bind dol_offset_loop_cfg dol_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk),
	.rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_start(rx_start),
	.sync_found(sync_found), .carrier_sense(carrier_sense),
	.loop_ctrl(loop_ctrl));
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import dol_pkg::*;
;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic rx_start = 0, sync_found = 0, carrier_sense = 0;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00, a, b;
	logic [7:0] reg_rdata;
	dol_loop_ctrl_t loop_ctrl;
	logic [7:0] q[$];
	int fails = 0, compares = 0;
	initial forever #10 clk = ~clk;
	dol_offset_loop_cfg u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .rx_start(rx_start), .sync_found(sync_found),
		.carrier_sense(carrier_sense), .loop_ctrl(loop_ctrl));
	// expected loop settings from both registers and the phase
	function automatic dol_loop_ctrl_t ex(input logic [7:0] f, t,
		input logic p, s);
		return '{f[5] & !s, (p & f[2]) ? 4'h1 : 4'({f[4:3], 1'b0}) + 4'h2,
			f[1:0], (p & t[3]) ? 4'h1 : 4'({t[7:6], 1'b0}) + 4'h2,
			(p & t[2]) ? 4'h2 : 4'({t[5:4], 1'b0}) + 4'h2, t[1:0]};
	endfunction : ex
	task chk8(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("mismatch %0t %h %h", $time, g, e);
		end
	endtask : chk8
	task chkc(input dol_loop_ctrl_t e);
		compares++;
		if (loop_ctrl !== e) begin
			fails++;
			$display("mismatch %0t %h %h", $time, loop_ctrl, e);
		end
	endtask : chkc
	task wr(input logic [5:0] ad, input logic [7:0] d);
		reg_addr = ad;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clk) reg_wr = 0;
		@(negedge clk);
	endtask : wr
	task rd(input logic [5:0] ad, input logic [7:0] e);
		reg_addr = ad;
		reg_rd = 1;
		q.push_back(e);
		@(negedge clk) reg_rd = 0;
		@(negedge clk);
	endtask : rd
	// read data lands just after the clock edge that samples the strobe
	always @(posedge clk) if (reg_rd === 1'b1) begin
		#1 chk8(reg_rdata, q.pop_front());
	end
	task results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	initial begin
		#100000 fails++;
		results;
	end
	// reset values, then random settings through a reception
	initial begin
		void'($urandom(31293));
		repeat (16) @(negedge clk);
		rst = 0;
		rd(6'h19, 8'h36);
		rd(6'h1a, 8'h6c);
		rd(6'h3f, 8'h00);
		chkc(ex(8'h36, 8'h6c, 0, 0));
		$display("test reset done");
		repeat (8) begin
			a = 8'($urandom);
			b = 8'($urandom);
			wr(DOL_ADDR_FREQ_CFG, a);
			wr(DOL_ADDR_TIMING_CFG, b);
			wr(6'h1b, a);
			rd(DOL_ADDR_FREQ_CFG, a & 8'h3f);
			rd(DOL_ADDR_TIMING_CFG, b);
			rd(6'h1b, 8'h00);
			rx_start = 1;
			@(negedge clk) rx_start = 0;
			chkc(ex(a, b, 0, 0));
			carrier_sense = 1;
			#1 chkc(ex(a, b, 0, 1));
			@(negedge clk) carrier_sense = 0;
			@(negedge clk) chkc(ex(a, b, 0, 1));
			sync_found = 1;
			#1 chkc(ex(a, b, 1, 1));
			@(negedge clk) sync_found = 0;
			#1 chkc(ex(a, b, 1, 1));
			@(negedge clk);
		end
		$display("test loop done");
		results;
	end
endmodule : tb_top
`default_nettype wire
